//--- src/dimr_mode_store.sv
`timescale 1ns/1ns
// holds the operating mode word, read data registered
module dimr_mode_store #(
    parameter int WIDTH = 18
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    // write side
    input  wire logic             wrEn,
    input  wire logic [WIDTH-1:0] wrData,
    // read side
    output logic      [WIDTH-1:0] rdData
);
    import dimr_pkg::*;

    // store the word; read data is the register itself
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdData <= MODE_RESET;
        end else if (wrEn) begin
            rdData <= wrData;
        end
    end

endmodule // dimr_mode_store

//--- src/dimr_pkg.sv
package dimr_pkg;

    // command encoding presented by the controller on the command pins
    typedef enum logic [2:0] {
        DIMR_CMD_NOP,
        DIMR_CMD_MODE_LOAD,
        DIMR_CMD_AUTO_REFRESH,
        DIMR_CMD_READ,
        DIMR_CMD_WRITE
    } dimr_cmd_e;

    // mode word layout
    localparam int MODE_WIDTH     = 18;
    localparam int ADDR_WIDTH     = 21;
    localparam int BANK_WIDTH     = 3;
    localparam int NUM_BANKS      = 8;
    localparam int CFG_LSB        = 0;
    localparam int CFG_MSB        = 2;
    localparam int BURST_LSB      = 3;
    localparam int BURST_MSB      = 4;
    localparam int ADDR_MUX_BIT   = 5;
    localparam int DLL_BIT        = 7;
    localparam int IMPEDANCE_BIT  = 8;
    localparam int TERM_BIT       = 9;

    // reset value: config 0, burst 2, non-multiplexed, dll reset, internal z, odt off
    localparam logic [17:0] MODE_RESET = 18'h0_0000;

    // burst length codes
    localparam logic [1:0] BURST_CODE_2   = 2'h0;
    localparam logic [1:0] BURST_CODE_4   = 2'h1;
    localparam logic [1:0] BURST_CODE_8   = 2'h2;
    localparam logic [1:0] BURST_CODE_RSV = 2'h3;

    // latencies, cycles
    localparam int LAT_WIDTH = 4;

    // initialization counts
    localparam int STABLE_TIME_US  = 200;
    localparam int CLK_MHZ         = 10;
    localparam int STABLE_CYCLES   = STABLE_TIME_US * CLK_MHZ;
    localparam int MIN_DUMMY_LOADS = 2;
    localparam int INIT_NOP_COUNT  = 1024;
    localparam int MODE_RECOVERY   = 6;
    localparam int DLL_LOCK_CYCLES = 1024;

    // decoded operating mode
    typedef struct packed {
        logic [3:0] rowCycle;
        logic [3:0] readLatency;
        logic [3:0] writeLatency;
        logic [3:0] burstLength;
        logic       addrMux;
        logic       dllEnable;
        logic       impedanceExt;
        logic       termEnable;
        logic       cfgError;
    } dimr_mode_s;

endpackage

//--- src/dram_init_mode_register.sv
`timescale 1ns/1ns
// What this block does
// - mode load with mux bit high enters multiplexed address mode.
// - multiplexed mode can also be entered later in operation.
// - mode word captured from the low eighteen address lines.
// - bits: termination 9, impedance 8, dll 7, mux 5; 6 unused.
// - config field bits 2..0 selects row cycle, read, write latency.
// - mux bit of the mode word picks the address mode.
// - burst field bits 4..3 selects 2, 4 or 8; 11 reserved.
module dram_init_mode_register #(
    parameter int STABLE_WAIT = dimr_pkg::STABLE_CYCLES
) (
    // clock and reset
    input  wire logic                                clk_sys,
    input  wire logic                                rst_b,
    // command and address pins
    input  wire dimr_pkg::dimr_cmd_e                 cmdPin,
    input  wire logic [dimr_pkg::ADDR_WIDTH-1:0]     addrPin,
    input  wire logic [dimr_pkg::BANK_WIDTH-1:0]     bankPin,
    // decoded mode and status
    output dimr_pkg::dimr_mode_s                     modeOut,
    output logic [dimr_pkg::MODE_WIDTH-1:0]          modeWord,
    output logic                                     initDone,
    output logic                                     dllLocked,
    output logic                                     seqError
);
    import dimr_pkg::*;

    typedef enum logic [2:0] {
        ST_STABLE, ST_LOADS, ST_RECOVER, ST_REFRESH, ST_READY
    } dimr_state_e;

    dimr_state_e                  state;
    dimr_state_e                  next_state;
    dimr_cmd_e                    cmdQ1;
    dimr_cmd_e                    cmdQ2;
    logic [ADDR_WIDTH-1:0]        addrQ1;
    logic [ADDR_WIDTH-1:0]        addrQ2;
    logic [BANK_WIDTH-1:0]        bankQ1;
    logic [BANK_WIDTH-1:0]        bankQ2;
    logic [15:0]                  stableCnt;
    logic [2:0]                   loadCnt;
    logic [3:0]                   recoverCnt;
    logic [10:0]                  nopCnt;
    logic [10:0]                  dllCnt;
    logic [NUM_BANKS-1:0]         bankRefreshed;
    logic                         loadCmd;
    logic                         muxPending;
    logic [MODE_WIDTH-1:0]        muxFirst;

    // decode config code into row cycle, read and write latency
    function automatic logic [11:0] cfgLatency(input logic [2:0] code);
        case (code)
            3'h0, 3'h1: cfgLatency = {4'h4, 4'h4, 4'h5};
            3'h2:       cfgLatency = {4'h6, 4'h6, 4'h7};
            3'h3:       cfgLatency = {4'h8, 4'h8, 4'h9};
            3'h4:       cfgLatency = {4'h3, 4'h3, 4'h4};
            3'h5:       cfgLatency = {4'h5, 4'h5, 4'h6};
            default:    cfgLatency = 12'h000;
        endcase
    endfunction

    // pins come from another domain: two-stage synchroniser
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cmdQ1  <= DIMR_CMD_NOP;
            cmdQ2  <= DIMR_CMD_NOP;
            addrQ1 <= '0;
            addrQ2 <= '0;
            bankQ1 <= '0;
            bankQ2 <= '0;
        end else begin
            cmdQ1  <= cmdPin;
            cmdQ2  <= cmdQ1;
            addrQ1 <= addrPin;
            addrQ2 <= addrQ1;
            bankQ1 <= bankPin;
            bankQ2 <= bankQ1;
        end
    end

    assign loadCmd = (cmdQ2 == DIMR_CMD_MODE_LOAD);

    // mode word: in multiplexed mode the load takes two cycles
    logic                  storeEn;
    logic [MODE_WIDTH-1:0] storeData;
    always_comb begin
        storeEn   = 1'b0;
        storeData = addrQ2[MODE_WIDTH-1:0];
        if (state == ST_STABLE) begin
            storeEn = 1'b0;
        end else if (modeWord[ADDR_MUX_BIT] && muxPending) begin
            // second half: ay3/ay4 feed cfg bits 1..2, ay9 feeds the dll bit 7
            storeEn   = 1'b1;
            storeData = muxFirst;
            storeData[2:1]   = addrQ2[4:3];
            storeData[DLL_BIT] = addrQ2[9];
        end else if (loadCmd && !modeWord[ADDR_MUX_BIT]) begin
            storeEn = 1'b1;
        end
    end

    // track first half of a multiplexed load
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            muxPending <= 1'b0;
            muxFirst   <= '0;
        end else if (muxPending) begin
            muxPending <= 1'b0;
        end else if (loadCmd && modeWord[ADDR_MUX_BIT] && state != ST_STABLE) begin
            muxPending <= 1'b1;
            muxFirst   <= addrQ2[MODE_WIDTH-1:0];
        end
    end

    dimr_mode_store #(
        .WIDTH (MODE_WIDTH)
    ) u_store (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .wrEn    (storeEn),
        .wrData  (storeData),
        .rdData  (modeWord)
    );

    // decoded mode fields
    always_comb begin
        logic [11:0] lat;
        lat = cfgLatency(modeWord[CFG_MSB:CFG_LSB]);
        modeOut.rowCycle     = lat[11:8];
        modeOut.readLatency  = lat[7:4] + {3'h0, modeWord[ADDR_MUX_BIT]};
        modeOut.writeLatency = lat[3:0] + {3'h0, modeWord[ADDR_MUX_BIT]};
        case (modeWord[BURST_MSB:BURST_LSB])
            BURST_CODE_2: modeOut.burstLength = 4'h2;
            BURST_CODE_4: modeOut.burstLength = 4'h4;
            BURST_CODE_8: modeOut.burstLength = 4'h8;
            default:      modeOut.burstLength = 4'h0;
        endcase
        modeOut.addrMux      = modeWord[ADDR_MUX_BIT];
        modeOut.dllEnable    = modeWord[DLL_BIT];
        modeOut.impedanceExt = modeWord[IMPEDANCE_BIT];
        modeOut.termEnable   = modeWord[TERM_BIT];
        // reserved codes, and burst 8 in the shortest configurations
        modeOut.cfgError = (lat == 12'h000)
            || (modeWord[BURST_MSB:BURST_LSB] == BURST_CODE_RSV)
            || ((modeWord[BURST_MSB:BURST_LSB] == BURST_CODE_8)
                && (modeWord[CFG_MSB:CFG_LSB] inside {3'h0, 3'h1, 3'h4}));
    end

    // initialization sequencer
    always_comb begin
        next_state = state;
        case (state)
            ST_STABLE:  if (stableCnt >= 16'(STABLE_WAIT) && loadCmd) next_state = ST_LOADS;
            ST_LOADS:   if (!loadCmd) begin
                            next_state = (loadCnt > 3'(MIN_DUMMY_LOADS)) ? ST_RECOVER
                                                                       : ST_STABLE;
                        end
            ST_RECOVER: if (recoverCnt >= 4'(MODE_RECOVERY - 1)) next_state = ST_REFRESH;
            ST_REFRESH: if (&bankRefreshed && nopCnt >= 11'(INIT_NOP_COUNT)) begin
                            next_state = ST_READY;
                        end
            ST_READY:   next_state = ST_READY;
            default:    next_state = ST_STABLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_STABLE;
        end else begin
            state <= next_state;
        end
    end

    // stable no-op time; any non-nop before the count reaches STABLE_WAIT restarts the wait
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            stableCnt <= '0;
        end else if (state != ST_STABLE) begin
            stableCnt <= '0;
        end else if (cmdQ2 != DIMR_CMD_NOP && stableCnt < 16'(STABLE_WAIT)) begin
            stableCnt <= '0;
        end else if (stableCnt < 16'(STABLE_WAIT)) begin
            stableCnt <= stableCnt + 16'h0001;
        end
    end

    // consecutive mode loads; recovery not checked between them
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            loadCnt <= '0;
        end else if (next_state == ST_LOADS && loadCnt != 3'h7) begin
            loadCnt <= loadCnt + 3'h1;
        end else if (next_state != ST_LOADS) begin
            loadCnt <= '0;
        end
    end

    // recovery after the valid load; the count is the distance from that load,
    // so a command on the sixth cycle after it is already taken as legal
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            recoverCnt <= '0;
        end else if (state == ST_RECOVER) begin
            recoverCnt <= recoverCnt + 4'h1;
        end else begin
            recoverCnt <= 4'h2;
        end
    end

    // refresh per bank and no-op count, in any order
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bankRefreshed <= '0;
            nopCnt        <= '0;
        end else if (state == ST_REFRESH) begin
            if (cmdQ2 == DIMR_CMD_AUTO_REFRESH) begin
                bankRefreshed[bankQ2] <= 1'b1;
            end
            if (cmdQ2 == DIMR_CMD_NOP && nopCnt < 11'(INIT_NOP_COUNT)) begin
                nopCnt <= nopCnt + 11'h001;
            end
        end
    end

    // dll lock counter cleared while the dll is held in reset
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dllCnt <= '0;
        end else if (!modeWord[DLL_BIT] || (storeEn && !storeData[DLL_BIT])) begin
            dllCnt <= '0;
        end else if (dllCnt < 11'(DLL_LOCK_CYCLES)) begin
            dllCnt <= dllCnt + 11'h001;
        end
    end

    // protocol error: read before lock, or command during a recovery
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            seqError <= 1'b0;
        end else if (state == ST_READY && cmdQ2 == DIMR_CMD_READ && !dllLocked) begin
            seqError <= 1'b1;
        end else if (state == ST_RECOVER && cmdQ2 != DIMR_CMD_NOP) begin
            seqError <= 1'b1;
        end
    end

    assign initDone  = (state == ST_READY);
    assign dllLocked = (dllCnt >= 11'(DLL_LOCK_CYCLES));

    chk_ready_needs_banks: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(initDone) |-> $past(&bankRefreshed))
        else $error("ready before every bank refreshed");
    chk_ready_needs_nops: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(initDone) |-> $past(nopCnt) == 11'(INIT_NOP_COUNT))
        else $error("ready before 1024 no-ops");
    chk_loads_after_wait: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (state == ST_STABLE && next_state == ST_LOADS) |-> stableCnt >= 16'(STABLE_WAIT))
        else $error("mode loads accepted before stable wait");
    chk_recover_length: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (state == ST_LOADS && next_state == ST_RECOVER)
        |=> (state == ST_RECOVER)[*4] ##1 (state == ST_REFRESH))
        else $error("recovery window of wrong length");
    chk_mux_second_half: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (modeWord[5] && muxPending) |=> (modeWord[2:1] == $past(addrQ2[4:3]))
        && (modeWord[7] == $past(addrQ2[9])))
        else $error("second half of multiplexed load not captured");
    chk_cfg_reserved: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (modeWord[2:0] == 3'h6) |-> modeOut.cfgError)
        else $error("reserved config not flagged");
    chk_latency_gap: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !modeOut.cfgError |-> modeOut.writeLatency == modeOut.readLatency + 4'h1)
        else $error("write latency not read plus one");
    chk_load_capture: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (storeEn && !modeWord[5]) |=> modeWord == $past(addrQ2[17:0]))
        else $error("mode word not captured");
    chk_dll_lock: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(dllLocked) |-> modeWord[7])
        else $error("lock without dll enabled");

endmodule // dram_init_mode_register

//--- verif/dimr_ctrl_model.sv
`timescale 1ns/1ns
// controller side of the pins; every change lands just after a falling edge
module dimr_ctrl_model #(
    parameter int STABLE_WAIT = 20
) (
    // clock
    input  wire logic                        clk_sys,
    // command, address and bank pins
    output dimr_pkg::dimr_cmd_e              cmdPin,
    output logic [dimr_pkg::ADDR_WIDTH-1:0]  addrPin,
    output logic [dimr_pkg::BANK_WIDTH-1:0]  bankPin
);
    import dimr_pkg::*;

    // quiet pins from time zero so nothing stray is registered
    initial begin
        cmdPin  = DIMR_CMD_NOP;
        addrPin = '0;
        bankPin = '0;
    end

    // one pin cycle, held for a whole clock period
    task automatic drive(input dimr_cmd_e c, input logic [ADDR_WIDTH-1:0] a,
                         input logic [BANK_WIDTH-1:0] b);
        @(negedge clk_sys);
        cmdPin  = c;
        addrPin = a;
        bankPin = b;
    endtask

    // no-op stretch; never any read, so lock wait is never broken
    task automatic nops(input int n);
        repeat (n) drive(DIMR_CMD_NOP, '0, '0);
    endtask

    // single-cycle load with idle banks, then the full recovery gap
    task automatic mload(input logic [ADDR_WIDTH-1:0] a);
        drive(DIMR_CMD_MODE_LOAD, a, '0);
        nops(MODE_RECOVERY + 1);
    endtask

    // two-cycle load once multiplexed addressing is on; ax keeps mux high
    task automatic mload2(input logic [ADDR_WIDTH-1:0] ax, input logic [ADDR_WIDTH-1:0] ay);
        drive(DIMR_CMD_MODE_LOAD, ax, '0);
        drive(DIMR_CMD_MODE_LOAD, ay, '0);
        nops(MODE_RECOVERY + 1);
    endtask

    // power-up: stable no-ops, dummies low, valid word, recovery, refreshes, no-ops
    task automatic init(input logic [ADDR_WIDTH-1:0] word);
        nops(STABLE_WAIT + 2);
        repeat (MIN_DUMMY_LOADS) drive(DIMR_CMD_MODE_LOAD, '0, '0);
        drive(DIMR_CMD_MODE_LOAD, word, '0);
        nops(MODE_RECOVERY);
        // no bank is touched again inside its row cycle after refresh
        for (int b = 0; b < NUM_BANKS; b++) begin
            drive(DIMR_CMD_AUTO_REFRESH, '0, b[2:0]);
        end
        nops(INIT_NOP_COUNT);
    endtask
endmodule // dimr_ctrl_model

//--- verif/test_dram_init_mode_register.sv
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin err_total++; \
    $display("ERROR %s expected %h seen %h", nm, (exp), (got)); end end
module test_dram_init_mode_register;
    import dimr_pkg::*;
    localparam int STABLE_SIM = 20;

    logic                    clk_sys;
    logic                    rst_b;
    dimr_cmd_e               cmdPin;
    logic [ADDR_WIDTH-1:0]   addrPin;
    logic [BANK_WIDTH-1:0]   bankPin;
    dimr_mode_s              modeOut;
    logic [MODE_WIDTH-1:0]   modeWord;
    logic                    initDone;
    logic                    dllLocked;
    logic                    seqError;
    int                      err_total = 0;
    int                      check_count = 0;
    int                      cycles = 0;
    // non-multiplexed row cycle equals read latency; write is one more
    logic [3:0]              rcTab [6] = '{4'h4, 4'h4, 4'h6, 4'h8, 4'h3, 4'h5};
    logic [20:0]             badWord [4] = '{21'h00_0006, 21'h00_0018, 21'h00_0010, 21'h00_0012};
    logic                    badErr [4] = '{1'b1, 1'b1, 1'b1, 1'b0};

    dram_init_mode_register #(.STABLE_WAIT(STABLE_SIM)) dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .cmdPin(cmdPin), .addrPin(addrPin),
        .bankPin(bankPin), .modeOut(modeOut), .modeWord(modeWord), .initDone(initDone),
        .dllLocked(dllLocked), .seqError(seqError));

    dimr_ctrl_model #(.STABLE_WAIT(STABLE_SIM)) ctrl (
        .clk_sys(clk_sys), .cmdPin(cmdPin), .addrPin(addrPin), .bankPin(bankPin));

    // 100 ns period
    initial clk_sys = 1'b0;
    always #50 clk_sys = ~clk_sys;

    // hang guard; whole run needs about 2300 cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_total++;
            final_report();
        end
    end

    task automatic final_report();
        if (err_total == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        rst_b = 1'b0;
        repeat (12) @(negedge clk_sys);
        `CHK("modeWord", 18'h0_0000, modeWord)
        `CHK("initDone", 1'b0, initDone)
        rst_b = 1'b1;
        // loads before the stable wait must be ignored
        repeat (3) ctrl.drive(DIMR_CMD_MODE_LOAD, ~addrPin, bankPin);
        ctrl.nops(8);
        `CHK("early modeWord", 18'h0_0000, modeWord)
        ctrl.init(21'h00_030A);
        ctrl.nops(4);
        `CHK("initDone", 1'b1, initDone)
        `CHK("modeWord", 18'h0_030A, modeWord)
        `CHK("termEnable", 1'b1, modeOut.termEnable)
        `CHK("impedanceExt", 1'b1, modeOut.impedanceExt)
        `CHK("burstLength", 4'h4, modeOut.burstLength)
        `CHK("rowCycle", 4'h6, modeOut.rowCycle)
        `CHK("addrMux", 1'b0, modeOut.addrMux)
        `CHK("dllLocked", 1'b0, dllLocked)
        // each latency code, with a don't-care address bit above the word
        for (int c = 0; c < 6; c++) begin
            ctrl.mload(21'h10_0000 | 21'(c));
            `CHK("modeWord", 18'(c), modeWord)
            `CHK("rowCycle", rcTab[c], modeOut.rowCycle)
            `CHK("readLatency", rcTab[c], modeOut.readLatency)
            `CHK("writeLatency", rcTab[c] + 4'h1, modeOut.writeLatency)
            `CHK("burstLength", 4'h2, modeOut.burstLength)
            `CHK("cfgError", 1'b0, modeOut.cfgError)
        end
        // reserved codes, and burst 8 both where it is not offered and where it is
        for (int k = 0; k < 4; k++) begin
            ctrl.mload(badWord[k]);
            `CHK("cfgError", badErr[k], modeOut.cfgError)
        end
        `CHK("burstLength", 4'h8, modeOut.burstLength)
        // dll enable after it was held in reset
        ctrl.mload(21'h00_0082);
        `CHK("dllEnable", 1'b1, modeOut.dllEnable)
        ctrl.nops(980);
        `CHK("dllLocked early", 1'b0, dllLocked)
        ctrl.nops(60);
        `CHK("dllLocked", 1'b1, dllLocked)
        // multiplexed addressing entered well after start-up
        ctrl.mload(21'h00_00A2);
        `CHK("addrMux", 1'b1, modeOut.addrMux)
        `CHK("modeWord", 18'h0_00A2, modeWord)
        `CHK("readLatency", 4'h7, modeOut.readLatency)
        `CHK("writeLatency", 4'h8, modeOut.writeLatency)
        // two-cycle word: ax bits 0,3,5; ay3 to bit1, ay9 to bit7
        ctrl.mload2(21'h00_0029, 21'h00_0208);
        `CHK("modeWord", 18'h0_00AB, modeWord)
        `CHK("rowCycle", 4'h8, modeOut.rowCycle)
        `CHK("readLatency", 4'h9, modeOut.readLatency)
        `CHK("burstLength", 4'h4, modeOut.burstLength)
        `CHK("seqError", 1'b0, seqError)
        // dll put back in reset, then re-enabled; a read before relock is flagged
        ctrl.mload2(21'h00_0029, 21'h00_0008);
        `CHK("modeWord", 18'h0_002B, modeWord)
        `CHK("dllEnable", 1'b0, modeOut.dllEnable)
        `CHK("dllLocked", 1'b0, dllLocked)
        ctrl.mload2(21'h00_0029, 21'h00_0208);
        ctrl.drive(DIMR_CMD_READ, addrPin, bankPin);
        ctrl.nops(3);
        `CHK("seqError read", 1'b1, seqError)
        // reset in mid-run clears mode, status and the sticky error
        rst_b = 1'b0;
        ctrl.nops(2);
        `CHK("seqError", 1'b0, seqError)
        `CHK("modeWord", 18'h0_0000, modeWord)
        `CHK("initDone", 1'b0, initDone)
        rst_b = 1'b1;
        // refresh pushed into the recovery gap; error must stick
        ctrl.nops(STABLE_SIM + 2);
        repeat (3) ctrl.drive(DIMR_CMD_MODE_LOAD, 21'h00_0000, bankPin);
        ctrl.nops(1);
        ctrl.drive(DIMR_CMD_AUTO_REFRESH, addrPin, 3'h3);
        ctrl.nops(4);
        `CHK("seqError", 1'b1, seqError)
        final_report();
    end
endmodule // test_dram_init_mode_register
